// ===== hdl/rcs_defs.svh
// Constants for the reset cause sequencer: offsets, fields, reset values, timing
// Notes on behaviour
// RULE1: Low-power and main brown-out requests are ORed into one generic brown-out reset.
// RULE2: Low-power monitor works only when its enable is programmed; erased means disabled.
// RULE3: Reset pin works when low-voltage programming or pin-enable is 1; off if both 0.
// RULE4: While the enabled reset pin is held low the device stays in reset.
// RULE5: Short low glitches on the reset pin are filtered out and cause no reset.
// RULE6: Internal reset sources never drive the reset pin low.
// RULE7: An external pin reset clears the pin-reset cause flag to 0.
// RULE8: Watchdog reset updates timeout, power-down, watchdog flag and window-violation flag; the code clears only timeout and the watchdog flag.
// RULE9: The reset instruction resets the device and clears its cause flag to 0.
// RULE10: Stack overflow/underflow resets only when enabled; the matching flag records it.
// RULE11: Leaving programming mode acts exactly like a power-on reset.
// RULE12: Enabled power-up timer counts 2048 slow-oscillator cycles, holding reset meanwhile.
// RULE13: Power-up timer starts only after power-on and brown-out conditions release.
// RULE14: Execution waits for power-up timer, oscillator start-up and reset pin release.
// RULE15: Timers run regardless of pin; execution starts 10 clocks after pin rises.
// RULE16: Resets set PC to 0; cause flags take the power-on, brown-out, fault patterns.
// RULE17: Watchdog wake-up continues at PC+2, status -00u uuuu, flags unchanged.
// RULE18: Window violation clears only bit 5; reset instruction clears only bit 2.
// RULE19: Only the flags matching the actual reset source change.
// RULE20: Software restores cause flags to inactive; hardware never does; the code's reset patterns set the watchdog and window flags to 1.
// RULE21: Software may write any flag active for testing without causing a reset.
// RULE22: Zero, carry, digit-carry reset only by power-on or brown-out; unused bits read 0.
// RULE23: Stack flags are active high; all other cause flags are active low.
// RULE24: Filtered reset pin is synchronised before it starts the release delay.
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

`define RCS_MCLK_HZ 125000000
`define RCS_SLOW_OSC_HZ 31000
`define RCS_SLOW_OSC_DIV (`RCS_MCLK_HZ / `RCS_SLOW_OSC_HZ)
`define RCS_PUT_NOMINAL_MS 66
`define RCS_PUT_TICKS 2048
`define RCS_RELEASE_CYCLES 10
`define RCS_PIN_FILTER_CYCLES 8

`define RCS_ADDR_W 14
`define RCS_IDX_BROWNOUT_CONTROL 12'he4b
`define RCS_IDX_RESET_CAUSE_FLAGS 12'hfd7
`define RCS_IDX_CORE_STATUS 12'hfd8
`define RCS_ADDR_BROWNOUT_CONTROL {`RCS_IDX_BROWNOUT_CONTROL, 2'b00}
`define RCS_ADDR_RESET_CAUSE_FLAGS {`RCS_IDX_RESET_CAUSE_FLAGS, 2'b00}
`define RCS_ADDR_CORE_STATUS {`RCS_IDX_CORE_STATUS, 2'b00}

`define RCS_FLAG_STACK_OVF 7
`define RCS_FLAG_STACK_UNF 6
`define RCS_FLAG_WINDOW 5
`define RCS_FLAG_WATCHDOG 4
`define RCS_FLAG_PIN 3
`define RCS_FLAG_SW_RESET 2
`define RCS_FLAG_POWERON 1
`define RCS_FLAG_BROWNOUT 0

`define RCS_CTRL_SW_BROWNOUT_EN 7
`define RCS_CTRL_READY 0

`define RCS_STATUS_TIMEOUT 6
`define RCS_STATUS_POWER_DOWN 5

`define RCS_FLAGS_POWERON 8'h3d
`define RCS_FLAGS_BROWNOUT_HI 6'h0f
`define RCS_FLAGS_FAULT_HI 7'h19
`define RCS_STATUS_POWERON 7'h60
`define RCS_CTRL_POWERON 1'b1

`endif

// ===== hdl/rcs_pkg.sv
// Types shared by the reset cause sequencer
package rcs_pkg;

    typedef enum logic [2:0] {
        RCS_ST_SUPPLY,
        RCS_ST_TIMERS,
        RCS_ST_PIN,
        RCS_ST_DELAY,
        RCS_ST_RUN
    } rcs_state_t;

    // Configuration fuses; enables marked _n are programmed by a 0
    typedef struct packed {
        logic low_power_monitor_enable;
        logic reset_pin_enable_cfg;
        logic low_voltage_programming_cfg;
        logic stack_reset_enable_cfg;
        logic power_up_timer_enable_n;
        logic osc_startup_required;
    } rcs_cfg_t;

    // One-cycle events from the core and the watchdog
    typedef struct packed {
        logic watchdog_timeout;
        logic window_violation;
        logic reset_instr;
        logic stack_overflow;
        logic stack_underflow;
        logic prog_mode_exit;
        logic ready_fault;
    } rcs_evt_t;

endpackage : rcs_pkg

// ===== hdl/rcs_delay_counter.sv
// Counts enabled ticks; done from the last one until cleared
`timescale 1ns/1ps
`default_nettype none
module rcs_delay_counter #(
    parameter int unsigned COUNT = 10
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic clear,
    input wire logic tick,
    // Result
    output logic done
);
    localparam int unsigned W = $clog2(COUNT + 1);

    if (COUNT < 1) begin : g_chk
        $error("rcs_delay_counter: COUNT must be at least 1");
    end

    logic [W-1:0] cnt_r;

    always_ff @(posedge mclk) begin
        if (rst || clear) begin
            cnt_r <= '0;
        end else if (tick && cnt_r != W'(COUNT)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Held after expiry so a late partner condition still sees the timer done
    assign done = (cnt_r == W'(COUNT)) || (tick && (cnt_r == W'(COUNT - 1)));

endmodule : rcs_delay_counter
`default_nettype wire

// ===== hdl/rcs_pin_filter.sv
// Glitch filter and synchroniser for the active-low reset pin
`timescale 1ns/1ps
`default_nettype none
module rcs_pin_filter #(
    parameter int unsigned FILTER_CYCLES = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Raw pin level
    input wire logic pin_in_n,
    // Filtered, synchronised level, high when released
    output logic pin_high
);
    localparam int unsigned W = $clog2(FILTER_CYCLES + 1);

    if (FILTER_CYCLES < 2) begin : g_chk
        $error("rcs_pin_filter: FILTER_CYCLES must be at least 2");
    end

    logic [W-1:0] cnt_r;
    logic filt_r;
    logic sync1_r;
    logic sync2_r;

    // New level is taken only after it stays put for the whole filter time
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= '0;
            filt_r <= 1'b1;
        end else if (pin_in_n == filt_r) begin
            cnt_r <= '0;
        end else if (cnt_r == W'(FILTER_CYCLES - 1)) begin
            cnt_r <= '0;
            filt_r <= pin_in_n; // RULE5
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= filt_r; // RULE24
            sync2_r <= sync1_r;
        end
    end

    assign pin_high = sync2_r;

    a_glitch_ignored: assert property (@(posedge mclk) disable iff (rst)
        $fell(filt_r) |-> $past(!pin_in_n, 2)) // RULE5
        else $error("filtered pin fell without a held low input");

endmodule : rcs_pin_filter
`default_nettype wire

// ===== hdl/rcs_sequencer.sv
// Reset cause sequencer: merges reset sources, times release, keeps cause flags
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defs.svh"
module rcs_sequencer
    import rcs_pkg::*;
#(
    parameter int unsigned SLOW_OSC_DIV = `RCS_SLOW_OSC_DIV,
    parameter int unsigned PUT_TICKS = `RCS_PUT_TICKS,
    parameter int unsigned RELEASE_CYCLES = `RCS_RELEASE_CYCLES,
    parameter int unsigned PIN_FILTER_CYCLES = `RCS_PIN_FILTER_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [`RCS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Supply monitors
    input wire logic poweron_req,
    input wire logic brownout_req,
    input wire logic low_power_supply_monitor,
    input wire logic brownout_ready,
    // External reset pin, active low
    input wire logic external_reset_pin_in_n,
    output logic external_reset_pin_out,
    output logic external_reset_pin_oe,
    // Configuration and core
    input wire rcs_cfg_t cfg,
    input wire rcs_evt_t evt,
    input wire logic core_asleep,
    input wire logic osc_startup_done,
    // Results
    output logic cpu_reset,
    output logic wake_continue,
    output logic software_brownout_enable
);
    if (SLOW_OSC_DIV < 2 || PUT_TICKS < 1 || RELEASE_CYCLES < 1) begin : g_chk
        $error("rcs_sequencer: divider, timer and delay counts out of range");
    end

    localparam int unsigned DW = $clog2(SLOW_OSC_DIV);

    rcs_state_t state_r;
    rcs_state_t state_nxt;
    logic [DW-1:0] div_r;
    logic slow_tick;
    logic gen_brownout;
    logic poweron_like;
    logic supply_hold;
    logic pin_en;
    logic pin_high;
    logic pin_hold;
    logic wdt_reset;
    logic wdt_wake;
    logic stack_reset;
    logic internal_reset;
    logic put_done;
    logic release_done;
    logic timers_ok;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [6:0] status_r;
    logic [6:0] status_nxt;
    logic ctrl_sben_r;
    logic cpu_reset_r;
    logic wake_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic wr_flags;
    logic wr_status;
    logic wr_ctrl;

    // Slow oscillator rate as a one-cycle enable
    always_ff @(posedge mclk) begin
        if (rst || div_r == DW'(SLOW_OSC_DIV - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end
    assign slow_tick = (div_r == DW'(SLOW_OSC_DIV - 1));

    // Source decode
    always_comb begin
        // Low-power monitor enable is programmed low; erased fuse reads 1
        gen_brownout = brownout_req
                       | (low_power_supply_monitor & ~cfg.low_power_monitor_enable); // RULE1 RULE2
        poweron_like = poweron_req | evt.prog_mode_exit; // RULE11
        supply_hold = poweron_like | gen_brownout | evt.ready_fault;
        pin_en = cfg.low_voltage_programming_cfg | cfg.reset_pin_enable_cfg; // RULE3
        pin_hold = pin_en & ~pin_high; // RULE4
        wdt_reset = evt.watchdog_timeout & ~core_asleep;
        wdt_wake = evt.watchdog_timeout & core_asleep & (state_r == RCS_ST_RUN);
        stack_reset = cfg.stack_reset_enable_cfg
                      & (evt.stack_overflow | evt.stack_underflow); // RULE10
        internal_reset = wdt_reset | evt.window_violation | evt.reset_instr | stack_reset;
        timers_ok = (cfg.power_up_timer_enable_n | put_done)
                    & (~cfg.osc_startup_required | osc_startup_done); // RULE14
    end

    rcs_pin_filter #(
        .FILTER_CYCLES(PIN_FILTER_CYCLES)
    ) u_pin (
        .mclk(mclk),
        .rst(rst),
        .pin_in_n(external_reset_pin_in_n),
        .pin_high(pin_high)
    );

    // Power-up timer counts only while the sequence sits in the timer state
    rcs_delay_counter #(
        .COUNT(PUT_TICKS)
    ) u_power_up_timer (
        .mclk(mclk),
        .rst(rst),
        .clear(state_r != RCS_ST_TIMERS), // RULE13
        .tick(slow_tick), // RULE12
        .done(put_done)
    );

    rcs_delay_counter #(
        .COUNT(RELEASE_CYCLES)
    ) u_release (
        .mclk(mclk),
        .rst(rst),
        .clear(state_r != RCS_ST_DELAY),
        .tick(1'b1),
        .done(release_done)
    );

    // Start-up sequence
    always_comb begin
        state_nxt = state_r;
        if (supply_hold) begin
            state_nxt = RCS_ST_SUPPLY;
        end else begin
            unique case (state_r)
                RCS_ST_SUPPLY: begin
                    state_nxt = RCS_ST_TIMERS;
                end
                RCS_ST_TIMERS: begin
                    // Timers run whatever the pin does
                    if (timers_ok) begin
                        state_nxt = RCS_ST_PIN; // RULE15
                    end
                end
                RCS_ST_PIN: begin
                    if (!pin_hold) begin
                        state_nxt = RCS_ST_DELAY;
                    end
                end
                RCS_ST_DELAY: begin
                    if (pin_hold) begin
                        state_nxt = RCS_ST_PIN;
                    end else if (release_done) begin
                        state_nxt = RCS_ST_RUN; // RULE15
                    end
                end
                RCS_ST_RUN: begin
                    if (pin_hold || internal_reset) begin
                        state_nxt = RCS_ST_PIN; // RULE4 RULE9
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= RCS_ST_SUPPLY;
            cpu_reset_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            // Core reload of PC to 0 is tied to this level
            cpu_reset_r <= (state_nxt != RCS_ST_RUN); // RULE16
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= wdt_wake && !supply_hold; // RULE17
        end
    end

    // Register bus: one wait state, the answer edge is where writes land
    assign wr_flags = avs_write && ack_r && avs_address == `RCS_ADDR_RESET_CAUSE_FLAGS;
    assign wr_status = avs_write && ack_r && avs_address == `RCS_ADDR_CORE_STATUS;
    assign wr_ctrl = avs_write && ack_r && avs_address == `RCS_ADDR_BROWNOUT_CONTROL;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (avs_read && !ack_r) begin
            unique case (avs_address)
                `RCS_ADDR_RESET_CAUSE_FLAGS: rdata_r <= {24'h00_0000, flags_r};
                `RCS_ADDR_CORE_STATUS: rdata_r <= {25'h000_0000, status_r}; // RULE22
                `RCS_ADDR_BROWNOUT_CONTROL: begin
                    rdata_r <= {24'h00_0000, ctrl_sben_r, 6'h00, brownout_ready};
                end
                default: rdata_r <= '0;
            endcase
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

    // Cause flags: software value first, hardware events override it
    always_comb begin
        flags_nxt = flags_r;
        if (wr_flags) begin
            flags_nxt = avs_writedata[7:0]; // RULE20 RULE21
        end
        if (poweron_like) begin
            flags_nxt = `RCS_FLAGS_POWERON; // RULE11 RULE16
        end else if (gen_brownout) begin
            flags_nxt[7:2] = `RCS_FLAGS_BROWNOUT_HI; // RULE1 RULE16
            flags_nxt[`RCS_FLAG_BROWNOUT] = 1'b0;
        end else if (evt.ready_fault) begin
            flags_nxt[7:1] = `RCS_FLAGS_FAULT_HI; // RULE16
        end else begin
            // Each source touches its own bit only
            if (pin_hold) begin
                flags_nxt[`RCS_FLAG_PIN] = 1'b0; // RULE7 RULE19
            end
            if (wdt_reset) begin
                flags_nxt[`RCS_FLAG_WATCHDOG] = 1'b0; // RULE8 RULE23
            end
            if (evt.window_violation) begin
                flags_nxt[`RCS_FLAG_WINDOW] = 1'b0; // RULE8 RULE18
            end
            if (evt.reset_instr) begin
                flags_nxt[`RCS_FLAG_SW_RESET] = 1'b0; // RULE9 RULE18
            end
            if (evt.stack_overflow) begin
                flags_nxt[`RCS_FLAG_STACK_OVF] = 1'b1; // RULE10 RULE23
            end
            if (evt.stack_underflow) begin
                flags_nxt[`RCS_FLAG_STACK_UNF] = 1'b1; // RULE10 RULE23
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_r <= `RCS_FLAGS_POWERON;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Core status: timeout, power-down and the low arithmetic bits
    always_comb begin
        status_nxt = status_r;
        if (wr_status) begin
            status_nxt[4:0] = avs_writedata[4:0];
        end
        if (poweron_like || gen_brownout) begin
            status_nxt = `RCS_STATUS_POWERON; // RULE22
        end else if (wdt_wake) begin
            status_nxt[`RCS_STATUS_TIMEOUT] = 1'b0; // RULE17
            status_nxt[`RCS_STATUS_POWER_DOWN] = 1'b0;
        end else if (wdt_reset) begin
            status_nxt[`RCS_STATUS_TIMEOUT] = 1'b0; // RULE8
        end else if (pin_hold && core_asleep && state_r == RCS_ST_RUN) begin
            status_nxt[`RCS_STATUS_TIMEOUT] = 1'b1;
            status_nxt[`RCS_STATUS_POWER_DOWN] = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            status_r <= `RCS_STATUS_POWERON;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_sben_r <= `RCS_CTRL_POWERON;
        end else if (poweron_like || gen_brownout) begin
            ctrl_sben_r <= `RCS_CTRL_POWERON;
        end else if (wr_ctrl) begin
            ctrl_sben_r <= avs_writedata[`RCS_CTRL_SW_BROWNOUT_EN];
        end
    end

    assign cpu_reset = cpu_reset_r;
    assign wake_continue = wake_r;
    assign software_brownout_enable = ctrl_sben_r;
    // The pin is input only; no reset source ever pulls it
    assign external_reset_pin_out = 1'b0; // RULE6
    assign external_reset_pin_oe = 1'b0; // RULE6

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_brownout_holds: assert property (gen_brownout |=> cpu_reset && state_r == RCS_ST_SUPPLY) // RULE1
        else $error("generic brown-out did not hold reset");
    a_lp_disabled: assert property ((cfg.low_power_monitor_enable && !brownout_req
        && !poweron_like && !evt.ready_fault && state_r == RCS_ST_RUN)
        |=> state_r != RCS_ST_SUPPLY) // RULE2
        else $error("disabled low-power monitor caused a reset");
    a_pin_disabled: assert property ((!pin_en && state_r == RCS_ST_RUN && !supply_hold
        && !internal_reset) |=> state_r == RCS_ST_RUN) // RULE3
        else $error("disabled pin caused a reset");
    a_pin_holds: assert property (pin_hold |=> cpu_reset ##1 cpu_reset) // RULE4
        else $error("low enabled pin did not hold reset");
    a_pin_undriven: assert property (!external_reset_pin_oe && !external_reset_pin_out) // RULE6
        else $error("reset pin driven");
    a_pin_flag: assert property ((pin_hold && !supply_hold) |=> !flags_r[`RCS_FLAG_PIN]) // RULE7
        else $error("pin reset flag not cleared");
    a_wdt_flags: assert property ((wdt_reset && !supply_hold)
        |=> !flags_r[`RCS_FLAG_WATCHDOG] && !status_r[`RCS_STATUS_TIMEOUT] && cpu_reset) // RULE8
        else $error("watchdog reset flags wrong");
    a_swrst_flag: assert property ((evt.reset_instr && !supply_hold && state_r == RCS_ST_RUN)
        |=> !flags_r[`RCS_FLAG_SW_RESET] && cpu_reset && $stable(status_r)) // RULE9
        else $error("reset instruction handling wrong");
    a_stack_gate: assert property ((evt.stack_overflow && !cfg.stack_reset_enable_cfg
        && state_r == RCS_ST_RUN && !supply_hold && !pin_hold && !evt.reset_instr
        && !evt.window_violation && !evt.watchdog_timeout)
        |=> state_r == RCS_ST_RUN && flags_r[`RCS_FLAG_STACK_OVF]) // RULE10
        else $error("stack event gating wrong");
    a_timer_gate: assert property ((state_r == RCS_ST_TIMERS && state_nxt == RCS_ST_PIN
        && !cfg.power_up_timer_enable_n) |-> put_done) // RULE12
        else $error("power-up timer skipped");
    a_release_delay: assert property (($rose(state_r == RCS_ST_RUN)
        && $past(state_r == RCS_ST_DELAY)) |-> $past(state_r == RCS_ST_DELAY, 10)) // RULE15
        else $error("release delay not ten cycles");
    a_flags_stable: assert property ((state_r == RCS_ST_RUN && !supply_hold && !pin_hold
        && evt == '0 && !wr_flags) |=> $stable(flags_r)) // RULE19
        else $error("cause flags changed without source");
    a_write_no_reset: assert property ((wr_flags && state_r == RCS_ST_RUN && !supply_hold
        && !pin_hold && evt == '0) |=> state_r == RCS_ST_RUN) // RULE21
        else $error("flag write caused a reset");

    c_power_to_run: cover property (state_r == RCS_ST_TIMERS ##[1:300] state_r == RCS_ST_RUN);
    c_wake: cover property (wdt_wake);
    c_pin_reset: cover property (state_r == RCS_ST_RUN ##1 pin_hold);
    c_window: cover property (evt.window_violation && state_r == RCS_ST_RUN);

endmodule : rcs_sequencer
`default_nettype wire

// ===== tb/rcs_pin_model.sv
// Reset pin driver: holds the active-low pin for a commanded span
`timescale 1ns/1ps
`default_nettype none
module rcs_pin_model (
    // Clock
    input wire logic mclk,
    // Command
    input wire logic press,
    input wire logic [7:0] len,
    // Pin, pulled up when released
    output logic pin_n
);
    logic [7:0] left_r = 8'h00;
    always_ff @(posedge mclk) begin
        if (press) begin
            left_r <= len;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end
    assign pin_n = (left_r == 8'h00);
endmodule : rcs_pin_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the reset cause sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defs.svh"
module tb_top;
    import rcs_pkg::*;
    localparam logic [13:0] FL = `RCS_ADDR_RESET_CAUSE_FLAGS;
    logic mclk = 0;
    logic rst = 1;
    logic [13:0] adr = 14'h0000;
    logic rd = 0;
    logic wr = 0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat, q;
    logic wq, pin_n, po, poe, cpu_reset, wake, sbe;
    logic pon = 0;
    logic slp = 0;
    logic bor = 0;
    logic lpm = 0;
    logic press = 0;
    logic [7:0] plen = 8'h00;
    logic [7:0] f;
    logic [7:0] clr [3] = '{8'h10, 8'h20, 8'h04};
    rcs_cfg_t cfg = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    rcs_evt_t evt = '0;
    int fail_count = 0;
    int cmp_count = 0;
    int seed = 72983;
    int k, n;
    int wk = 0;
    always #4 mclk = ~mclk;
    always @(negedge mclk) begin
        if (wake === 1'b1) wk++;
    end
    rcs_sequencer #(.SLOW_OSC_DIV(4), .PUT_TICKS(4)) uut (.mclk(mclk), .rst(rst),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdat), .avs_waitrequest(wq), .poweron_req(pon), .brownout_req(bor),
        .low_power_supply_monitor(lpm), .brownout_ready(1'b1), .external_reset_pin_in_n(pin_n),
        .external_reset_pin_out(po), .external_reset_pin_oe(poe), .cfg(cfg), .evt(evt),
        .core_asleep(slp), .osc_startup_done(1'b1), .cpu_reset(cpu_reset),
        .wake_continue(wake), .software_brownout_enable(sbe));
    rcs_pin_model pm (.mclk(mclk), .press(press), .len(plen), .pin_n(pin_n));
    function automatic logic [7:0] exp_sup(input int s, input logic [7:0] p);
        return (s == 4) ? 8'h3d : {6'h0f, p[1], 1'b0};
    endfunction : exp_sup
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
        @(posedge mclk);
        adr <= a;
        wd <= {24'h00_0000, d};
        rd <= ~w;
        wr <= w;
        @(negedge mclk);
        while (wq !== 1'b0) begin
            @(negedge mclk);
        end
        @(posedge mclk);
        q = rdat;
        rd <= 0;
        wr <= 0;
    endtask : bus
    task automatic wait_run;
        n = 0;
        @(negedge mclk);
        while (cpu_reset !== 1'b0 && n < 400) begin
            n++;
            @(negedge mclk);
        end
        chk(cpu_reset, 0);
    endtask : wait_run
    task automatic pulse(input rcs_evt_t e);
        @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= '0;
        repeat (2) @(negedge mclk);
    endtask : pulse
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 0;
        wait_run();
        bus(0, FL, 0);
        chk(q, 32'h0000_003d);
        bus(0, `RCS_ADDR_CORE_STATUS, 0);
        chk(q, 32'h0000_0060);
        bus(0, `RCS_ADDR_BROWNOUT_CONTROL, 0);
        chk(q, 32'h0000_0081);
        chk(sbe, 1);
        bus(0, 14'h0100, 0);
        chk(q, 32'h0000_0000);
        repeat (6) begin
            f = 8'($random(seed));
            bus(1, FL, f);
            bus(0, FL, 0);
            chk(q, {24'h00_0000, f});
            chk(cpu_reset, 0);
        end
        for (k = 0; k < 3; k++) begin
            bus(1, FL, 8'h3f);
            pulse(rcs_evt_t'(7'h40 >> k));
            chk(cpu_reset, 1);
            wait_run();
            bus(0, FL, 0);
            chk(q, {24'h00_0000, 8'h3f & ~clr[k]});
            if (k == 0) begin
                bus(0, `RCS_ADDR_CORE_STATUS, 0);
                chk(q & 32'h0000_0060, 32'h0000_0020);
            end
        end
        bus(1, FL, 8'h3f);
        pulse(rcs_evt_t'(7'h08));
        chk(cpu_reset, 0);
        bus(0, FL, 0);
        chk(q, 32'h0000_00bf);
        cfg.stack_reset_enable_cfg <= 1'b1;
        pulse(rcs_evt_t'(7'h04));
        chk(cpu_reset, 1);
        wait_run();
        bus(0, FL, 0);
        chk(q, 32'h0000_00ff);
        bus(1, `RCS_ADDR_BROWNOUT_CONTROL, 8'h00);
        bus(0, `RCS_ADDR_BROWNOUT_CONTROL, 0);
        chk(q, 32'h0000_0001);
        chk(sbe, 0);
        for (k = 1; k < 5; k = k * 2) begin
            f = 8'($random(seed));
            bus(1, FL, f);
            @(posedge mclk);
            {pon, bor, lpm} <= 3'(k);
            repeat (3) @(posedge mclk);
            {pon, bor, lpm} <= 3'b000;
            wait_run();
            chk(n >= 25 && n <= 28, 1);
            bus(0, FL, 0);
            chk(q, {24'h00_0000, exp_sup(k, f)});
        end
        chk(sbe, 1);
        cfg.low_power_monitor_enable <= 1'b1;
        lpm <= 1'b1;
        repeat (4) @(negedge mclk);
        chk(cpu_reset, 0);
        bus(1, FL, 8'h3f);
        lpm <= 1'b0;
        plen <= 8'h03;
        press <= 1'b1;
        @(posedge mclk);
        press <= 1'b0;
        repeat (20) @(negedge mclk);
        chk(cpu_reset, 0);
        @(posedge mclk);
        plen <= 8'h28;
        press <= 1'b1;
        @(posedge mclk);
        press <= 1'b0;
        repeat (16) @(negedge mclk);
        chk(cpu_reset, 1);
        chk({po, poe}, 0);
        bus(0, FL, 0);
        chk(q, 32'h0000_0037);
        @(posedge pin_n);
        wait_run();
        chk(n >= 10 && n <= 24, 1);
        @(posedge mclk);
        slp <= 1'b1;
        pulse(rcs_evt_t'(7'h40));
        chk(wk, 1);
        chk(cpu_reset, 0);
        bus(0, `RCS_ADDR_CORE_STATUS, 0);
        chk(q & 32'h0000_0060, 32'h0000_0000);
        bus(0, FL, 0);
        chk(q, 32'h0000_0037);
        bus(1, FL, 8'hc0);
        pulse(rcs_evt_t'(7'h01));
        wait_run();
        bus(0, FL, 0);
        chk(q, 32'h0000_0032);
        pulse(rcs_evt_t'(7'h02));
        wait_run();
        bus(0, FL, 0);
        chk(q, 32'h0000_003d);
        cfg.reset_pin_enable_cfg <= 1'b0;
        press <= 1'b1;
        @(posedge mclk);
        press <= 1'b0;
        repeat (16) @(negedge mclk);
        chk(cpu_reset, 0);
        @(posedge mclk);
        cfg.low_voltage_programming_cfg <= 1'b1;
        repeat (4) @(negedge mclk);
        chk(cpu_reset, 1);
        @(posedge pin_n);
        wait_run();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
